// >>> hw/timer_params.svh
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

`define BUS_ADDR_WIDTH 8
`define BUS_DATA_WIDTH 32
`define TMR_WIDTH 16
`define PRE_WIDTH 8

`define OFF_CON_EVEN 8'h00
`define OFF_CNT_EVEN 8'h04
`define OFF_PER_EVEN 8'h08
`define OFF_CON_ODD 8'h0C
`define OFF_CNT_ODD 8'h10
`define OFF_PER_ODD 8'h14
`define OFF_STATUS 8'h18

`define BIT_ON 15
`define BIT_STOP_IN_IDLE 13
`define BIT_GATE 7
`define PS_HI 6
`define PS_LO 4
`define BIT_PAIR 3
`define BIT_TCS 1

`define CON_MASK_EVEN 16'hA0FA
`define CON_MASK_ODD 16'hA0F2
`define CON_RESET 16'h0000
`define CNT_RESET 16'h0000
`define PER_RESET 16'hFFFF
`define STATUS_RESET 8'h00

`define PIN_EXT_EVEN 0
`define PIN_EXT_ODD 1
`define PIN_GATE_EVEN 2
`define PIN_GATE_ODD 3
`define PIN_COUNT 4

`define PS_LIM_1 8'h00
`define PS_LIM_2 8'h01
`define PS_LIM_4 8'h03
`define PS_LIM_8 8'h07
`define PS_LIM_16 8'h0F
`define PS_LIM_32 8'h1F
`define PS_LIM_64 8'h3F
`define PS_LIM_256 8'hFF

`endif

// >>> hw/timer_pkg.sv
`include "timer_params.svh"

package timer_pkg;

    typedef struct packed {
        logic [`PIN_COUNT-1:0] sync1;
        logic [`PIN_COUNT-1:0] sync2;
        logic [`PIN_COUNT-1:0] sync3;
        logic [`PIN_COUNT-1:0] pin_lvl;
        logic [`TMR_WIDTH-1:0] con_even;
        logic [`TMR_WIDTH-1:0] con_odd;
        logic [`TMR_WIDTH-1:0] cnt_even;
        logic [`TMR_WIDTH-1:0] cnt_odd;
        logic [`TMR_WIDTH-1:0] per_even;
        logic [`TMR_WIDTH-1:0] per_odd;
        logic [`BUS_DATA_WIDTH-1:0] rdata;
        logic match_even;
        logic match_odd;
    } timer_state_type;

    typedef struct packed {
        logic [`PRE_WIDTH-1:0] count;
    } prescale_state_type;

    function automatic logic [`PRE_WIDTH-1:0] prescale_limit(input logic [2:0] code);
        logic [`PRE_WIDTH-1:0] lim;
        lim = `PS_LIM_1;
        unique case (code)
            3'h0: lim = `PS_LIM_1;
            3'h1: lim = `PS_LIM_2;
            3'h2: lim = `PS_LIM_4;
            3'h3: lim = `PS_LIM_8;
            3'h4: lim = `PS_LIM_16;
            3'h5: lim = `PS_LIM_32;
            3'h6: lim = `PS_LIM_64;
            3'h7: lim = `PS_LIM_256;
        endcase
        return lim;
    endfunction

endpackage

// >>> hw/prescale_if.sv
`timescale 1ns/10ps
interface prescale_if;
    logic clear;
    logic tick_in;
    logic [2:0] code;
    logic tick_out;

    modport ctl (
        output clear,
        output tick_in,
        output code,
        input tick_out
    );

    modport pre (
        input clear,
        input tick_in,
        input code,
        output tick_out
    );
endinterface

// >>> hw/timer_prescaler.sv
`timescale 1ns/10ps
`include "timer_params.svh"

module timer_prescaler
    import timer_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    prescale_if.pre port
);
    prescale_state_type st_reg;
    prescale_state_type st_next;
    logic [`PRE_WIDTH-1:0] limit;
    logic at_limit;

    assign limit = prescale_limit(port.code);
    assign at_limit = (st_reg.count == limit);
    assign port.tick_out = port.tick_in & at_limit & ~port.clear;

    always_comb begin
        st_next = st_reg;
        if (port.clear) begin
            st_next.count = '0;
        end else if (port.tick_in) begin
            if (at_limit) begin
                st_next.count = '0;
            end else begin
                st_next.count = st_reg.count + `PRE_WIDTH'(1);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule

// >>> hw/general_timer_control.sv
// Notes on behaviour
// - Enable bit 15 runs or stops timer
// - Stop-in-idle bit 13 halts timer during idle
// - External clock: gate bit ignored, reads zero
// - Internal clock: gate bit enables gated accumulation
// - Prescale bits 6-4 divide 1 to 256
// - Pair bit 3 only on even timer
// - Paired: odd timer settings have no effect except stop-in-idle bit 13, which also halts the pair
// - Unimplemented control bits ignore writes, read zero
`timescale 1ns/10ps
`include "timer_params.svh"

module general_timer_control
    import timer_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [`BUS_ADDR_WIDTH-1:0] bus_addr,
    input wire logic [`BUS_DATA_WIDTH-1:0] bus_wdata,
    input wire logic bus_write,
    input wire logic bus_read,
    output logic [`BUS_DATA_WIDTH-1:0] bus_rdata,
    input wire logic idle_mode,
    input wire logic ext_clk_even,
    input wire logic ext_clk_odd,
    input wire logic gate_even,
    input wire logic gate_odd,
    output logic match_even,
    output logic match_odd,
    output logic running_even,
    output logic running_odd
);
    timer_state_type st_reg;
    timer_state_type st_next;

    prescale_if pre_even ();
    prescale_if pre_odd ();

    logic [`PIN_COUNT-1:0] pins;
    logic [`PIN_COUNT-1:0] pin_settled;
    logic [`PIN_COUNT-1:0] pin_rise;

    logic pair;
    logic on_even;
    logic on_odd;
    logic tcs_even;
    logic tcs_odd;
    logic gated_even;
    logic gated_odd;
    logic halt_even;
    logic halt_odd;
    logic run_even;
    logic run_odd;
    logic src_even;
    logic src_odd;
    logic pass_even;
    logic pass_odd;
    logic [2*`TMR_WIDTH-1:0] wide_cnt;
    logic [2*`TMR_WIDTH-1:0] wide_per;
    logic [`BUS_DATA_WIDTH-1:0] read_word;
    logic [7:0] status_bits;

    // Only the bits a timer really has are kept; the rest never leave zero
    function automatic logic [`TMR_WIDTH-1:0] con_store(
        input logic [`TMR_WIDTH-1:0] wdata,
        input logic [`TMR_WIDTH-1:0] mask
    );
        return wdata & mask;
    endfunction

    // Gate bit is hidden while the external clock is selected
    function automatic logic [`BUS_DATA_WIDTH-1:0] con_view(
        input logic [`TMR_WIDTH-1:0] con
    );
        logic [`TMR_WIDTH-1:0] v;
        v = con;
        if (con[`BIT_TCS]) begin
            v[`BIT_GATE] = 1'b0;
        end
        return {{(`BUS_DATA_WIDTH - `TMR_WIDTH){1'b0}}, v};
    endfunction

    function automatic logic [`BUS_DATA_WIDTH-1:0] half_view(
        input logic [`TMR_WIDTH-1:0] val
    );
        return {{(`BUS_DATA_WIDTH - `TMR_WIDTH){1'b0}}, val};
    endfunction

    assign pins[`PIN_EXT_EVEN] = ext_clk_even;
    assign pins[`PIN_EXT_ODD] = ext_clk_odd;
    assign pins[`PIN_GATE_EVEN] = gate_even;
    assign pins[`PIN_GATE_ODD] = gate_odd;

    // A pin level counts only once the last two sync stages agree
    assign pin_settled = ~(st_reg.sync2 ^ st_reg.sync3);
    assign pin_rise = pin_settled & st_reg.sync2 & ~st_reg.pin_lvl;

    assign pair = st_reg.con_even[`BIT_PAIR];
    assign on_even = st_reg.con_even[`BIT_ON];
    assign on_odd = st_reg.con_odd[`BIT_ON];
    assign tcs_even = st_reg.con_even[`BIT_TCS];
    assign tcs_odd = st_reg.con_odd[`BIT_TCS];

    assign gated_even = st_reg.con_even[`BIT_GATE] & ~tcs_even;
    assign gated_odd = st_reg.con_odd[`BIT_GATE] & ~tcs_odd;

    // A paired timer also stops in idle if the odd half asks for it
    assign halt_even = idle_mode
        & (st_reg.con_even[`BIT_STOP_IN_IDLE] | (pair & st_reg.con_odd[`BIT_STOP_IN_IDLE]));
    assign halt_odd = idle_mode & st_reg.con_odd[`BIT_STOP_IN_IDLE];

    assign run_even = on_even & ~halt_even;
    assign run_odd = ~pair & on_odd & ~halt_odd;

    assign src_even = tcs_even ? pin_rise[`PIN_EXT_EVEN] : 1'b1;
    assign src_odd = tcs_odd ? pin_rise[`PIN_EXT_ODD] : 1'b1;

    assign pass_even = ~gated_even | st_reg.pin_lvl[`PIN_GATE_EVEN];
    assign pass_odd = ~gated_odd | st_reg.pin_lvl[`PIN_GATE_ODD];

    assign pre_even.clear = ~run_even;
    assign pre_even.tick_in = run_even & src_even & pass_even;
    assign pre_even.code = st_reg.con_even[`PS_HI:`PS_LO];

    // Odd prescaler sits cleared while paired, so its settings do nothing
    assign pre_odd.clear = ~run_odd;
    assign pre_odd.tick_in = run_odd & src_odd & pass_odd;
    assign pre_odd.code = st_reg.con_odd[`PS_HI:`PS_LO];

    timer_prescaler u_pre_even (
        .sys_clk(sys_clk),
        .reset(reset),
        .port(pre_even)
    );

    timer_prescaler u_pre_odd (
        .sys_clk(sys_clk),
        .reset(reset),
        .port(pre_odd)
    );

    assign wide_cnt = {st_reg.cnt_odd, st_reg.cnt_even};
    assign wide_per = {st_reg.per_odd, st_reg.per_even};

    assign status_bits = {2'b00, st_reg.pin_lvl[`PIN_GATE_ODD],
        st_reg.pin_lvl[`PIN_GATE_EVEN], 1'b0, pair, run_odd, run_even};

    always_comb begin
        read_word = '0;
        unique case (bus_addr)
            `OFF_CON_EVEN: read_word = con_view(st_reg.con_even);
            `OFF_CNT_EVEN: read_word = half_view(st_reg.cnt_even);
            `OFF_PER_EVEN: read_word = half_view(st_reg.per_even);
            `OFF_CON_ODD: read_word = con_view(st_reg.con_odd);
            `OFF_CNT_ODD: read_word = half_view(st_reg.cnt_odd);
            `OFF_PER_ODD: read_word = half_view(st_reg.per_odd);
            `OFF_STATUS: read_word = {{(`BUS_DATA_WIDTH - 8){1'b0}}, status_bits};
            default: read_word = '0;
        endcase
    end

    always_comb begin
        st_next = st_reg;
        st_next.match_even = 1'b0;
        st_next.match_odd = 1'b0;
        st_next.rdata = '0;

        st_next.sync1 = pins;
        st_next.sync2 = st_reg.sync1;
        st_next.sync3 = st_reg.sync2;
        for (int i = 0; i < `PIN_COUNT; i++) begin
            if (pin_settled[i]) begin
                st_next.pin_lvl[i] = st_reg.sync2[i];
            end
        end

        if (pair) begin
            // Even and odd halves form one wide counter driven by even settings
            if (pre_even.tick_out) begin
                if (wide_cnt == wide_per) begin
                    st_next.cnt_even = '0;
                    st_next.cnt_odd = '0;
                    st_next.match_even = 1'b1;
                end else begin
                    {st_next.cnt_odd, st_next.cnt_even} = wide_cnt + (2*`TMR_WIDTH)'(1);
                end
            end
        end else begin
            if (pre_even.tick_out) begin
                if (st_reg.cnt_even == st_reg.per_even) begin
                    st_next.cnt_even = '0;
                    st_next.match_even = 1'b1;
                end else begin
                    st_next.cnt_even = st_reg.cnt_even + `TMR_WIDTH'(1);
                end
            end
            if (pre_odd.tick_out) begin
                if (st_reg.cnt_odd == st_reg.per_odd) begin
                    st_next.cnt_odd = '0;
                    st_next.match_odd = 1'b1;
                end else begin
                    st_next.cnt_odd = st_reg.cnt_odd + `TMR_WIDTH'(1);
                end
            end
        end

        // Software writes take priority over counting in the same cycle
        if (bus_write) begin
            unique case (bus_addr)
                `OFF_CON_EVEN: begin
                    st_next.con_even = con_store(bus_wdata[`TMR_WIDTH-1:0],
                        `CON_MASK_EVEN);
                end
                `OFF_CNT_EVEN: begin
                    st_next.cnt_even = bus_wdata[`TMR_WIDTH-1:0];
                end
                `OFF_PER_EVEN: begin
                    st_next.per_even = bus_wdata[`TMR_WIDTH-1:0];
                end
                `OFF_CON_ODD: begin
                    st_next.con_odd = con_store(bus_wdata[`TMR_WIDTH-1:0],
                        `CON_MASK_ODD);
                end
                `OFF_CNT_ODD: begin
                    st_next.cnt_odd = bus_wdata[`TMR_WIDTH-1:0];
                end
                `OFF_PER_ODD: begin
                    st_next.per_odd = bus_wdata[`TMR_WIDTH-1:0];
                end
                default: begin
                end
            endcase
        end

        // No wait states, so access right after disabling is harmless here
        if (bus_read) begin
            st_next.rdata = read_word;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_reg <= '0;
            st_reg.con_even <= `CON_RESET;
            st_reg.con_odd <= `CON_RESET;
            st_reg.cnt_even <= `CNT_RESET;
            st_reg.cnt_odd <= `CNT_RESET;
            st_reg.per_even <= `PER_RESET;
            st_reg.per_odd <= `PER_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign bus_rdata = st_reg.rdata;
    assign match_even = st_reg.match_even;
    assign match_odd = st_reg.match_odd;
    assign running_even = run_even;
    assign running_odd = run_odd;
endmodule

// >>> sim/general_timer_control_assertions.sv
`timescale 1ns/10ps
`include "timer_params.svh"

module general_timer_control_checker (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [`BUS_ADDR_WIDTH-1:0] bus_addr,
    input wire logic [`BUS_DATA_WIDTH-1:0] bus_wdata,
    input wire logic bus_write,
    input wire logic bus_read,
    input wire logic [`BUS_DATA_WIDTH-1:0] bus_rdata,
    input wire logic idle_mode,
    input wire logic ext_clk_even,
    input wire logic ext_clk_odd,
    input wire logic gate_even,
    input wire logic gate_odd,
    input wire logic match_even,
    input wire logic match_odd,
    input wire logic running_even,
    input wire logic running_odd
);
    logic [15:0] sh_even_reg;
    logic [15:0] sh_odd_reg;
    logic run_e;
    logic run_o;
    logic rd_even;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    // Shadow of the control words as written, so run state can be predicted
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sh_even_reg <= 16'h0000;
        end else if (bus_write && bus_addr == `OFF_CON_EVEN) begin
            sh_even_reg <= bus_wdata[15:0];
        end
    end
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sh_odd_reg <= 16'h0000;
        end else if (bus_write && bus_addr == `OFF_CON_ODD) begin
            sh_odd_reg <= bus_wdata[15:0];
        end
    end
    assign run_e = sh_even_reg[15] && !(idle_mode && (sh_even_reg[13]
        || (sh_even_reg[3] && sh_odd_reg[13])));
    assign run_o = !sh_even_reg[3] && sh_odd_reg[15] && !(idle_mode && sh_odd_reg[13]);

    always_ff @(posedge sys_clk) begin
        rd_even <= bus_read && bus_addr == `OFF_CON_EVEN;
    end

    chk_reset_clean: assert property ($past(reset) |-> bus_rdata == 32'h0
        && !match_even && !match_odd) else $error("outputs not clear after reset");
    chk_rdata_quiet: assert property (!$past(bus_read) |-> bus_rdata == 32'h0)
        else $error("read data outside read slot");
    chk_unimpl_even: assert property (rd_even |-> (bus_rdata & 32'hFFFF5F05) == 32'h0)
        else $error("unimplemented even control bit set");
    chk_unimpl_odd: assert property ($past(bus_read) && $past(bus_addr) == `OFF_CON_ODD
        |-> (bus_rdata & 32'hFFFF5F0D) == 32'h0) else $error("odd control reads extra bits");
    chk_gate_hidden: assert property (rd_even && bus_rdata[1] |-> !bus_rdata[7])
        else $error("gate bit visible with external clock");
    chk_enable_run: assert property (running_even == run_e)
        else $error("even run state wrong");
    chk_pair_odd_off: assert property (running_odd == run_o)
        else $error("odd run state wrong");
    chk_match_cause: assert property (match_even |-> $past(running_even)
        || $past(running_even, 2)) else $error("match while stopped");
    chk_pair_no_odd: assert property (sh_even_reg[3] && $past(sh_even_reg[3])
        && $past(sh_even_reg[3], 2) |-> !match_odd) else $error("odd match when paired");
endmodule

bind general_timer_control general_timer_control_checker u_chk (.sys_clk(sys_clk),
    .reset(reset), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_write(bus_write),
    .bus_read(bus_read), .bus_rdata(bus_rdata), .idle_mode(idle_mode),
    .ext_clk_even(ext_clk_even), .ext_clk_odd(ext_clk_odd), .gate_even(gate_even),
    .gate_odd(gate_odd), .match_even(match_even), .match_odd(match_odd),
    .running_even(running_even), .running_odd(running_odd));

// >>> sim/general_timer_control_bench.sv
`timescale 1ns/10ps
`include "timer_params.svh"

module general_timer_control_bench;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] bus_addr = 8'h00;
    logic [31:0] bus_wdata = 32'h0;
    logic bus_write = 1'b0;
    logic bus_read = 1'b0;
    logic [31:0] bus_rdata;
    logic idle_mode = 1'b0;
    logic ext_clk_even = 1'b0;
    logic ext_clk_odd = 1'b0;
    logic gate_even = 1'b0;
    logic gate_odd = 1'b0;
    logic match_even;
    logic match_odd;
    logic running_even;
    logic running_odd;
    int error_cnt = 0;
    int samples_checked = 0;

    general_timer_control u_dut (.sys_clk(sys_clk), .reset(reset), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read),
        .bus_rdata(bus_rdata), .idle_mode(idle_mode), .ext_clk_even(ext_clk_even),
        .ext_clk_odd(ext_clk_odd), .gate_even(gate_even), .gate_odd(gate_odd),
        .match_even(match_even), .match_odd(match_odd), .running_even(running_even),
        .running_odd(running_odd));

    always #5 sys_clk = ~sys_clk;

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_write <= 1'b1;
        @(posedge sys_clk);
        bus_write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_read <= 1'b1;
        @(posedge sys_clk);
        bus_read <= 1'b0;
        #1 d = bus_rdata;
    endtask

    task automatic rd_cmp(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        cmp(d, exp);
    endtask

    task automatic t_regs;
        rd_cmp(`OFF_CON_EVEN, 32'h0);
        rd_cmp(`OFF_CON_ODD, 32'h0);
        wr(`OFF_CON_EVEN, 32'hFFFF5F05);
        rd_cmp(`OFF_CON_EVEN, 32'h0);
        wr(`OFF_CON_EVEN, 32'h000020FA);
        rd_cmp(`OFF_CON_EVEN, 32'h0000207A);
        wr(`OFF_CON_ODD, 32'hFFFF20FA);
        rd_cmp(`OFF_CON_ODD, 32'h00002072);
        wr(`OFF_CON_ODD, 32'h0);
        rd_cmp(8'h40, 32'h0);
    endtask

    // Interval between matches is (period + 1) times the ratio
    task automatic t_prescale;
        int ratio [8] = '{1, 2, 4, 8, 16, 32, 64, 256};
        int n;
        wr(`OFF_PER_EVEN, 32'h1);
        for (int c = 0; c < 8; c++) begin
            wr(`OFF_CON_EVEN, 32'h8000 | (c << 4));
            for (int k = 0; k < 2; k++) begin
                n = 0;
                do begin
                    @(posedge sys_clk);
                    #1 n++;
                end while (match_even !== 1'b1 && n < 2000);
            end
            cmp(n, 2 * ratio[c]);
            wr(`OFF_CON_EVEN, 32'h0);
        end
        wr(`OFF_PER_EVEN, 32'hFFFF);
    endtask

    task automatic t_gate;
        logic [31:0] d;
        wr(`OFF_CNT_EVEN, 32'h0);
        wr(`OFF_CON_EVEN, 32'h8080);
        repeat (10) @(posedge sys_clk);
        rd_cmp(`OFF_CNT_EVEN, 32'h0);
        @(posedge sys_clk);
        gate_even <= 1'b1;
        repeat (10) @(posedge sys_clk);
        wr(`OFF_CON_EVEN, 32'h0080);
        rd(`OFF_CNT_EVEN, d);
        cmp(d != 0, 1);
        rd_cmp(`OFF_CON_EVEN, 32'h0080);
        @(posedge sys_clk);
        gate_even <= 1'b0;
    endtask

    // Gate held low must not block external edges
    task automatic t_ext;
        wr(`OFF_CNT_EVEN, 32'h0);
        wr(`OFF_CNT_ODD, 32'h0);
        wr(`OFF_CON_ODD, 32'h8082);
        wr(`OFF_CON_EVEN, 32'h8082);
        repeat (5) begin
            repeat (4) @(posedge sys_clk);
            ext_clk_even <= 1'b1;
            ext_clk_odd <= 1'b1;
            repeat (4) @(posedge sys_clk);
            ext_clk_even <= 1'b0;
            ext_clk_odd <= 1'b0;
        end
        repeat (8) @(posedge sys_clk);
        wr(`OFF_CON_EVEN, 32'h0);
        wr(`OFF_CON_ODD, 32'h0);
        rd_cmp(`OFF_CNT_EVEN, 32'h5);
        rd_cmp(`OFF_CNT_ODD, 32'h5);
    endtask

    task automatic t_idle;
        wr(`OFF_CNT_EVEN, 32'h0);
        idle_mode <= 1'b1;
        wr(`OFF_CON_EVEN, 32'hA000);
        #1 cmp(running_even, 1'b0);
        repeat (10) @(posedge sys_clk);
        rd_cmp(`OFF_CNT_EVEN, 32'h0);
        wr(`OFF_CON_EVEN, 32'h8000);
        #1 cmp(running_even, 1'b1);
        @(posedge sys_clk);
        idle_mode <= 1'b0;
        wr(`OFF_CON_EVEN, 32'h0);
        #1 cmp(running_even, 1'b0);
    endtask

    task automatic t_pair;
        wr(`OFF_CNT_EVEN, 32'hFFF0);
        wr(`OFF_CNT_ODD, 32'h0);
        wr(`OFF_CON_ODD, 32'h0070);
        idle_mode <= 1'b1;
        wr(`OFF_CON_EVEN, 32'h8008);
        #1 cmp(running_odd, 1'b0);
        cmp(running_even, 1'b1);
        repeat (30) @(posedge sys_clk);
        idle_mode <= 1'b0;
        wr(`OFF_CON_EVEN, 32'h0);
        rd_cmp(`OFF_CNT_ODD, 32'h1);
    endtask

    // Odd timer on its own: gate blocks, then match pulses every two ticks
    task automatic t_odd;
        int n;
        wr(`OFF_CNT_ODD, 32'h0);
        wr(`OFF_PER_ODD, 32'h1);
        wr(`OFF_CON_ODD, 32'h8080);
        #1 cmp(running_odd, 1'b1);
        repeat (10) @(posedge sys_clk);
        rd_cmp(`OFF_CNT_ODD, 32'h0);
        @(posedge sys_clk);
        gate_odd <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                @(posedge sys_clk);
                #1 n++;
            end while (match_odd !== 1'b1 && n < 100);
        end
        cmp(n, 2);
        @(posedge sys_clk);
        gate_odd <= 1'b0;
        wr(`OFF_CON_ODD, 32'h0);
        wr(`OFF_PER_ODD, 32'hFFFF);
    endtask

    initial begin
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        t_regs();
        t_prescale();
        t_gate();
        t_ext();
        t_idle();
        t_pair();
        t_odd();
        close_out();
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        close_out();
    end
endmodule
